/* File: sma_consts.vh */
// constants for the switch memory access controller
`ifndef SMA_CONSTS_VH
`define SMA_CONSTS_VH
// register word indices, matched against address bits 3:2
`define SMA_OFS_DATA      2'h0
`define SMA_OFS_ADDR      2'h1
`define SMA_OFS_CMD       2'h2
`define SMA_OFS_STATUS    2'h3
`define SMA_RST_REG       8'h00
// command register fields
`define SMA_CMD_RD_BIT    7
`define SMA_OPC_HI        6
`define SMA_OPC_LO        3
`define SMA_CODE_HI       3
`define SMA_CODE_LO       0
`define SMA_STAT_BUSY_BIT 0
`define SMA_ADDR_UD_BIT   7
// operation codes
`define SMA_OPC_TS_ONE    4'hc
`define SMA_OPC_TS_ALL    4'hd
`define SMA_OPC_CTL_DATA  4'h9
`define SMA_OPC_CTL_BOTH  3'h7
// control memory codes
`define SMA_CODE_NONE     4'h0
`define SMA_CODE_SW8      4'h1
`define SMA_CODE_SW4_LO   4'h2
`define SMA_CODE_SW4_HI   4'h3
`define SMA_CODE_SW2_0    4'h4
`define SMA_CODE_SW2_1    4'h5
`define SMA_CODE_SW2_2    4'h6
`define SMA_CODE_SW2_3    4'h7
`define SMA_CODE_PRE_0    4'h8
`define SMA_CODE_UP       4'h9
`define SMA_CODE_PRE_1    4'ha
`define SMA_CODE_PRE_2    4'hb
// slot kinds
`define SMA_KIND_NONE     2'h0
`define SMA_KIND_SW       2'h1
`define SMA_KIND_PRE      2'h2
`define SMA_KIND_UP       2'h3
// timing in reference clock cycles (single access in tenths)
`define SMA_ONE_TENTHS    95
`define SMA_ONE_CYC       (`SMA_ONE_TENTHS / 10)
`define SMA_ALL_CYC       1035
`define SMA_TS_SLOTS      128
`define SMA_CTL_SLOTS     256
`endif

/* File: sma_ctrl.v */
// switch memory access controller: command interpreter and pcm tristate
`timescale 1ns/10ps
`include "sma_consts.vh"
// Function
// - tristate field upstream only, per subslot
// - driven slot: send data, control low
// - floated slot: no drive, control high
// - four code bits, one = drive
// - code bit n controls slot bits 2n+1..2n
// - tristate field writable and readable
// - op 1100 exchanges one slot code
// - op 1101 fills all, 1035 cycles
// - tristate accesses force upstream select
// - data entry meaning follows slot code
// - op 111x writes data and code
// - op 1001 touches data field only
// - four bit code per interface slot
// - 111x read returns code, ignores bits
// - decode control memory code table
// - single access done within 9.5 cycles
module sma_ctrl (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire [6:0]  pcm_slot_i,
  input  wire [2:0]  pcm_bit_i,
  input  wire        pcm_data_i,
  output wire        pcm_txd_o,
  output wire        pcm_txd_oe_o,
  output wire        tristate_ctrl_output_n_o,
  input  wire [7:0]  ifc_slot_i,
  output wire [7:0]  ifc_data_o,
  output wire [3:0]  ifc_code_o,
  output wire [1:0]  ifc_kind_o,
  output wire [7:0]  ifc_bits_o,
  output wire        mem_access_busy_flag_o
);

////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 1'b0;
localparam ST_RUN  = 1'b1;
localparam [10:0] LIM_ONE = `SMA_ONE_CYC - 1;
localparam [10:0] LIM_ALL = `SMA_ALL_CYC - 1;
localparam [10:0] TS_N    = `SMA_TS_SLOTS;

function [1:0] sma_kind;
  input [3:0] code;
  begin
    case (code)
      `SMA_CODE_NONE:
        sma_kind = `SMA_KIND_NONE;
      `SMA_CODE_PRE_0, `SMA_CODE_PRE_1, `SMA_CODE_PRE_2:
        sma_kind = `SMA_KIND_PRE;
      `SMA_CODE_UP:
        sma_kind = `SMA_KIND_UP;
      `SMA_CODE_SW8, `SMA_CODE_SW4_LO, `SMA_CODE_SW4_HI,
      `SMA_CODE_SW2_0, `SMA_CODE_SW2_1, `SMA_CODE_SW2_2, `SMA_CODE_SW2_3:
        sma_kind = `SMA_KIND_SW;
      default:
        sma_kind = `SMA_KIND_NONE;
    endcase
  end
endfunction

function [7:0] sma_bits;
  input [3:0] code;
  begin
    case (code)
      `SMA_CODE_SW8:    sma_bits = 8'hff;
      `SMA_CODE_SW4_HI: sma_bits = 8'hf0;
      `SMA_CODE_SW4_LO: sma_bits = 8'h0f;
      `SMA_CODE_SW2_3:  sma_bits = 8'hc0;
      `SMA_CODE_SW2_2:  sma_bits = 8'h30;
      `SMA_CODE_SW2_1:  sma_bits = 8'h0c;
      `SMA_CODE_SW2_0:  sma_bits = 8'h03;
      `SMA_CODE_UP:     sma_bits = 8'hff;
      default:         sma_bits = 8'h00;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
reg  [7:0]  mem_access_data_reg_r;
reg  [7:0]  mem_access_addr_reg_r;
reg  [7:0]  mem_access_cmd_reg_r;
reg         busy_r;
reg         st_r;
reg  [10:0] cnt_r;
reg  [10:0] lim_r;
reg         ack_r;
reg  [31:0] rdata_r;
reg  [3:0]  ts_mem [0:`SMA_TS_SLOTS-1];
reg  [7:0]  ctl_data [0:`SMA_CTL_SLOTS-1];
reg  [3:0]  ctl_code [0:`SMA_CTL_SLOTS-1];
reg         txd_r;
reg         oe_r;
reg         drv_n_r;
reg  [7:0]  ifc_data_r;
reg  [3:0]  ifc_code_r;
reg  [1:0]  ifc_kind_r;
reg  [7:0]  ifc_bits_r;
// one loop index per process, so each has a single driver
integer     i;
integer     j;

wire        req      = avs_read_i | avs_write_i;
wire        wr_fire  = avs_write_i & ack_r & avs_byteenable_i[0];
wire [1:0]  reg_sel  = avs_address_i[3:2];
wire        byte_ok  = (avs_address_i[1:0] == 2'h0);
wire [7:0]  wbyte    = avs_writedata_i[7:0];
wire [3:0]  memory_op_code     = mem_access_cmd_reg_r[`SMA_OPC_HI:`SMA_OPC_LO];
wire [3:0]  ctrl_mem_code_bits = mem_access_cmd_reg_r[`SMA_CODE_HI:`SMA_CODE_LO];
wire        op_rd    = mem_access_cmd_reg_r[`SMA_CMD_RD_BIT];
wire [6:0]  ts_idx   = mem_access_addr_reg_r[6:0];
wire [7:0]  ctl_idx  = mem_access_addr_reg_r;
wire        done     = (st_r == ST_RUN) & (cnt_r == lim_r);
wire        op_ts1   = (memory_op_code == `SMA_OPC_TS_ONE);
wire        op_tsa   = (memory_op_code == `SMA_OPC_TS_ALL);
wire        op_cmd   = (memory_op_code == `SMA_OPC_CTL_DATA);
wire        op_cmb   = (memory_op_code[3:1] == `SMA_OPC_CTL_BOTH);
wire        walk_wr  = (st_r == ST_RUN) & op_tsa & (cnt_r < TS_N);
wire [3:0]  ts_sel   = ts_mem[pcm_slot_i];

// one wait cycle per access keeps read data registered
assign avs_waitrequest_o = req & ~ack_r;
assign avs_readdata_o    = rdata_r;
assign mem_access_busy_flag_o   = busy_r;
assign pcm_txd_o                = txd_r;
assign pcm_txd_oe_o             = oe_r;
assign tristate_ctrl_output_n_o = drv_n_r;
assign ifc_data_o = ifc_data_r;
assign ifc_code_o = ifc_code_r;
assign ifc_kind_o = ifc_kind_r;
assign ifc_bits_o = ifc_bits_r;

////////////////////////////////////////////////////////////////////////
// bus slave, command sequencer
always @(posedge clk_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    ack_r   <= 1'b0;
    rdata_r <= 32'h0;
    mem_access_data_reg_r <= `SMA_RST_REG;
    mem_access_addr_reg_r <= `SMA_RST_REG;
    mem_access_cmd_reg_r  <= `SMA_RST_REG;
    busy_r  <= 1'b0;
    st_r    <= ST_IDLE;
    cnt_r   <= 11'h0;
    lim_r   <= 11'h0;
  end
  else
  begin
    ack_r <= req & ~ack_r;
    if (req & ~ack_r)
    begin
      rdata_r <= 32'h0;
      if (avs_read_i & byte_ok)
      begin
        case (reg_sel)
          `SMA_OFS_DATA:   rdata_r[7:0] <= mem_access_data_reg_r;
          `SMA_OFS_ADDR:   rdata_r[7:0] <= mem_access_addr_reg_r;
          `SMA_OFS_CMD:    rdata_r[7:0] <= mem_access_cmd_reg_r;
          `SMA_OFS_STATUS: rdata_r[`SMA_STAT_BUSY_BIT] <= busy_r;
          default:         rdata_r <= 32'h0;
        endcase
      end
    end
    // writes while busy are dropped so the running access stays consistent
    if (wr_fire & byte_ok & ~busy_r)
    begin
      case (reg_sel)
        `SMA_OFS_DATA:
          mem_access_data_reg_r <= wbyte;
        `SMA_OFS_ADDR:
          mem_access_addr_reg_r <= wbyte;
        `SMA_OFS_CMD:
        begin
          mem_access_cmd_reg_r <= wbyte;
          busy_r <= 1'b1;
          st_r   <= ST_RUN;
          cnt_r  <= 11'h0;
          if (wbyte[`SMA_OPC_HI:`SMA_OPC_LO] == `SMA_OPC_TS_ALL)
            lim_r <= LIM_ALL;
          else
            lim_r <= LIM_ONE;
        end
        default:
          busy_r <= busy_r;
      endcase
    end
    if (st_r == ST_RUN)
    begin
      cnt_r <= cnt_r + 11'h1;
      if (done)
      begin
        st_r   <= ST_IDLE;
        busy_r <= 1'b0;
        if (op_rd & op_ts1)
          mem_access_data_reg_r <= {4'h0, ts_mem[ts_idx]};
        else if (op_rd & op_cmb)
          mem_access_data_reg_r <= {4'h0, ctl_code[ctl_idx]};
        else if (op_rd & op_cmd)
          mem_access_data_reg_r <= ctl_data[ctl_idx];
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// tristate field; index drops the select bit, upstream is implied
always @(posedge clk_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    for (i = 0; i < `SMA_TS_SLOTS; i = i + 1)
      ts_mem[i] <= 4'h0;
  end
  else
  begin
    if (walk_wr)
      ts_mem[cnt_r[6:0]] <= mem_access_data_reg_r[3:0];
    else if (done & op_ts1 & ~op_rd)
      ts_mem[ts_idx] <= mem_access_data_reg_r[3:0];
  end
end

////////////////////////////////////////////////////////////////////////
// control memory data and code fields
always @(posedge clk_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    for (j = 0; j < `SMA_CTL_SLOTS; j = j + 1)
    begin
      ctl_data[j] <= 8'h00;
      ctl_code[j] <= `SMA_CODE_NONE;
    end
  end
  else if (done & ~op_rd)
  begin
    if (op_cmb)
    begin
      ctl_data[ctl_idx] <= mem_access_data_reg_r;
      ctl_code[ctl_idx] <= ctrl_mem_code_bits;
    end
    else if (op_cmd)
      ctl_data[ctl_idx] <= mem_access_data_reg_r;
  end
end

////////////////////////////////////////////////////////////////////////
// pcm transmit driver; a set code bit drives its 2-bit subslot
always @(posedge clk_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    txd_r   <= 1'b0;
    oe_r    <= 1'b0;
    drv_n_r <= 1'b1;
  end
  else
  begin
    txd_r   <= pcm_data_i & ts_sel[pcm_bit_i[2:1]];
    oe_r    <= ts_sel[pcm_bit_i[2:1]];
    drv_n_r <= ~ts_sel[pcm_bit_i[2:1]];
  end
end

////////////////////////////////////////////////////////////////////////
// interface slot lookup: kind gives the meaning of the data entry
always @(posedge clk_i or negedge arst_n_i)
begin
  if (!arst_n_i)
  begin
    ifc_data_r <= 8'h00;
    ifc_code_r <= `SMA_CODE_NONE;
    ifc_kind_r <= `SMA_KIND_NONE;
    ifc_bits_r <= 8'h00;
  end
  else
  begin
    ifc_data_r <= ctl_data[ifc_slot_i];
    ifc_code_r <= ctl_code[ifc_slot_i];
    ifc_kind_r <= sma_kind(ctl_code[ifc_slot_i]);
    ifc_bits_r <= sma_bits(ctl_code[ifc_slot_i]);
  end
end

endmodule

/* File: sma_ctrl_props.sv */
// port assertions for the switch memory access controller
`timescale 1ns/10ps
module sma_ctrl_chk (
  input wire        clk_i,
  input wire        arst_n_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        pcm_data_i,
  input wire        pcm_txd_o,
  input wire        pcm_txd_oe_o,
  input wire        tristate_ctrl_output_n_o,
  input wire [3:0]  ifc_code_o,
  input wire [1:0]  ifc_kind_o,
  input wire [7:0]  ifc_bits_o,
  input wire        mem_access_busy_flag_o
);
  // busy length; 11 bits hold the full fill
  reg  [10:0] bcnt_r;
  wire        bsy = mem_access_busy_flag_o;
  wire        acc = !avs_waitrequest_o;
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      bcnt_r <= 11'h000;
    else
      bcnt_r <= bsy ? bcnt_r + 11'h001 : 11'h000;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  one_wait_a: assert property ((avs_read_i | avs_write_i) && !acc |=> acc)
    else $error("no answer after one wait state");
  drive_low_a: assert property (pcm_txd_oe_o |->
    !tristate_ctrl_output_n_o && pcm_txd_o == $past(pcm_data_i)) else $error("driven slot");
  float_high_a: assert property (!pcm_txd_oe_o |->
    tristate_ctrl_output_n_o && !pcm_txd_o) else $error("floated slot");
  busy_set_a: assert property (avs_write_i && acc && avs_byteenable_i[0] &&
    avs_address_i == 4'h8 && !bsy |=> bsy) else $error("busy not set");
  busy_len_a: assert property ($fell(bsy) |->
    bcnt_r == 11'h009 || bcnt_r == 11'h40b) else $error("busy length");
  stat_busy_a: assert property (avs_read_i && acc && avs_address_i == 4'hc |->
    avs_readdata_o[0] == $past(bsy)) else $error("status busy bit");
  up_kind_a: assert property (ifc_code_o == 4'h9 |->
    ifc_kind_o == 2'h3 && ifc_bits_o == 8'hff) else $error("up channel decode");
  pre_kind_a: assert property (ifc_code_o == 4'h8 || ifc_code_o[3:1] == 3'h5 |->
    ifc_kind_o == 2'h2 && ifc_bits_o == 8'h00) else $error("preprocessed decode");
endmodule

/* File: sma_pcm_model.sv */
// pcm highway model: slot and bit counters with a changing data pattern
`timescale 1ns/10ps
module sma_pcm_model (
  input  wire       clk_i,
  input  wire       arst_n_i,
  output reg  [6:0] pcm_slot_o,
  output reg  [2:0] pcm_bit_o,
  output wire       pcm_data_o
);
  // pattern changes every other bit and at each slot end so a stale txd shows
  assign pcm_data_o = pcm_slot_o[0] ^ pcm_bit_o[1] ^ pcm_bit_o[0];
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      pcm_slot_o <= 7'h00;
      pcm_bit_o  <= 3'h7;
    end
    else
    begin
      pcm_bit_o <= pcm_bit_o - 3'h1;
      if (pcm_bit_o == 3'h0)
        pcm_slot_o <= pcm_slot_o + 7'h01;
    end
endmodule

/* File: testbench.sv */
// self-checking bench for the switch memory access controller
`timescale 1ns/10ps
module testbench;
  reg         clk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [7:0]  wdat = 8'h00;
  reg  [31:0] q;
  reg  [3:0]  exp_ts [0:127];
  reg  [9:0]  kb [0:11] = '{10'h000, 10'h1ff, 10'h10f, 10'h1f0, 10'h103, 10'h10c,
                           10'h130, 10'h1c0, 10'h200, 10'h3ff, 10'h200, 10'h200};
  wire [31:0] rdat;
  wire        wreq, oe, busy, pdat, txd, drv_n;
  wire [6:0]  pslot;
  wire [2:0]  pbit;
  wire [7:0]  cdat, cbits;
  wire [3:0]  ccode;
  wire [1:0]  ckind;
  integer     n_errors = 0;
  integer     n_compared = 0;
  integer     k, n;
  real        t0;
  always #12.5 clk_i = ~clk_i;
  sma_pcm_model sma_pcm_model_i (.clk_i, .arst_n_i, .pcm_slot_o(pslot), .pcm_bit_o(pbit),
    .pcm_data_o(pdat));
  sma_ctrl sma_ctrl_i (.clk_i, .arst_n_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i({24'h0, wdat}), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pcm_slot_i(pslot), .pcm_bit_i(pbit),
    .pcm_data_i(pdat), .pcm_txd_o(txd), .pcm_txd_oe_o(oe), .tristate_ctrl_output_n_o(drv_n),
    .ifc_slot_i(8'hfb), .ifc_data_o(cdat), .ifc_code_o(ccode), .ifc_kind_o(ckind),
    .ifc_bits_o(cbits), .mem_access_busy_flag_o(busy));
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish(input t);
    begin
      n_errors = n_errors + t;
      if (n_errors == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input w, input [3:0] a, input [7:0] d);
    integer i;
    begin
      @(posedge clk_i);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20; i = i + 1)
      begin
        @(posedge clk_i);
        if (wreq === 1'b0)
          i = 30;
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (i == 20)
        tally_and_finish(1'b1);
    end
  endtask
  // mid: poke status and data while busy; n returns busy cycles
  task cmd(input [7:0] c, input mid);
    begin
      bus(1'b1, 4'h8, c);
      t0 = $realtime;
      if (mid)
      begin
        bus(1'b0, 4'hc, 8'h00);
        chk(q, 32'h1);
        bus(1'b1, 4'h0, 8'h03);
      end
      #1;
      for (n = 0; n < 2000 && busy !== 1'b0; n = n + 1)
        @(posedge clk_i) #1;
      if (n == 2000)
        tally_and_finish(1'b1);
      n = ($realtime - t0) / 25.0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task s_fill;
    begin
      bus(1'b1, 4'h0, 8'h5a);
      cmd(8'h68, 1'b1);
      chk(n, 1035);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h5a);
      for (k = 0; k < 128; k = k + 1)
        exp_ts[k] = 4'ha;
    end
  endtask
  // written with select bit 0, read back with it 1: same slot
  task s_one;
    begin
      bus(1'b1, 4'h0, 8'hf9);
      bus(1'b1, 4'h4, 8'h2a);
      cmd(8'h60, 1'b0);
      chk(n, 9);
      exp_ts[42] = 4'h9;
      bus(1'b1, 4'h0, 8'h00);
      bus(1'b1, 4'h4, 8'haa);
      cmd(8'he0, 1'b0);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h9);
    end
  endtask
  // stride two keeps one bit of every subslot over a whole frame
  task s_pcm;
    reg [6:0] s;
    reg [2:0] b;
    reg       p;
    reg       e;
    begin
      for (k = 0; k < 600; k = k + 1)
      begin
        @(negedge clk_i);
        s = pslot;
        b = pbit;
        p = pdat;
        e = exp_ts[s][b[2:1]];
        @(negedge clk_i);
        chk({oe, drv_n, txd}, {e, !e, p & e});
      end
    end
  endtask
  // reset during a fill: idle levels, status clear, walked slot cleared
  task s_rst;
    begin
      bus(1'b1, 4'h0, 8'hff);
      bus(1'b1, 4'h8, 8'h68);
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b0;
      @(negedge clk_i);
      chk({rdat, busy, oe, drv_n, txd, ccode, cdat}, {32'h0, 4'h2, 12'h000});
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, 4'hc, 8'h00);
      chk(q, 32'h0);
      bus(1'b1, 4'h4, 8'h80);
      cmd(8'he0, 1'b0);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h0);
    end
  endtask
  task s_cm;
    begin
      bus(1'b1, 4'h0, 8'hc6);
      bus(1'b1, 4'h4, 8'hfb);
      cmd(8'h71, 1'b0);
      cmd(8'hf6, 1'b0);
      bus(1'b0, 4'h0, 8'h00);
      chk(q, 32'h1);
      chk({cdat, ccode, ckind, cbits}, {8'hc6, 4'h1, 10'h1ff});
      bus(1'b1, 4'h0, 8'h3c);
      cmd(8'h48, 1'b0);
      bus(1'b1, 4'h0, 8'h00);
      cmd(8'hc8, 1'b0);
      bus(1'b0, 4'h0, 8'h00);
      chk({q[7:0], cdat, ccode}, {8'h3c, 8'h3c, 4'h1});
      for (k = 0; k < 12; k = k + 1)
      begin
        cmd({4'h7, k[3:0]}, 1'b0);
        repeat (2) @(posedge clk_i);
        chk({ckind, cbits}, kb[k]);
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    s_fill;
    s_one;
    s_pcm;
    s_cm;
    s_rst;
    tally_and_finish(1'b0);
  end
endmodule
bind sma_ctrl sma_ctrl_chk sma_ctrl_chk_i (.clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pcm_data_i,
  .pcm_txd_o, .pcm_txd_oe_o, .tristate_ctrl_output_n_o, .ifc_code_o, .ifc_kind_o,
  .ifc_bits_o, .mem_access_busy_flag_o);
